// [design/stdiag_regs.svh]
// offsets, field positions, reset values and timing of the diag bank
`ifndef STDIAG_REGS_SVH
`define STDIAG_REGS_SVH
`define STDIAG_ADDR_CFG         5'h0e
`define STDIAG_ADDR_SCRATCH     5'h0f
`define STDIAG_ADDR_MON         5'h10
`define STDIAG_ADDR_BIST        5'h11
`define STDIAG_CFG_TRIG_BIT     15
`define STDIAG_CFG_EN_BIT       10
`define STDIAG_LIMIT_MSB        9
`define STDIAG_LIMIT_RESET      10'h12c
`define STDIAG_LIMIT_SAT        10'h3ff
`define STDIAG_EN_RESET         1'b1
`define STDIAG_SCRATCH_RESET    16'h0000
`define STDIAG_MON_RESET        16'h0000
`define STDIAG_BIST_RESET       16'h0000
`define STDIAG_BIST_ANALOG_BIT  15
`define STDIAG_BIST_LOGIC_BIT   14
`define STDIAG_BIST_ERR_BIT     13
`define STDIAG_BIST_MASK        16'he000
`define STDIAG_BIST_FAULT_MASK  16'hc000
`define STDIAG_TICK_MS          1
`define STDIAG_CLK_MHZ          250
`define STDIAG_MS_CYCLES (`STDIAG_TICK_MS * `STDIAG_CLK_MHZ * 1000)
`endif

// [design/stdiag_pkg.sv]
// types shared by the diag bank modules
package stdiag_pkg;
  typedef logic [15:0] stdiag_word_t;
  typedef logic [4:0]  stdiag_addr_t;
  typedef enum logic [2:0] {
    STDIAG_SEL_NONE,
    STDIAG_SEL_CFG,
    STDIAG_SEL_SCRATCH,
    STDIAG_SEL_MON,
    STDIAG_SEL_BIST
  } stdiag_sel_t;
endpackage : stdiag_pkg

// [design/stdiag_xfer_if.sv]
// request and answer carrier between the link port and the core
`timescale 1ns/1ps
interface stdiag_xfer_if;
  logic                    req_tgl;
  logic                    ack_tgl;
  logic                    write;
  stdiag_pkg::stdiag_addr_t addr;
  stdiag_pkg::stdiag_word_t wdata;
  stdiag_pkg::stdiag_word_t rdata;
  modport link (output req_tgl, output write, output addr, output wdata,
                input ack_tgl, input rdata);
  modport core (input req_tgl, input write, input addr, input wdata,
                output ack_tgl, output rdata);
endinterface : stdiag_xfer_if

// [design/stdiag_link.sv]
// link-side request port of the diag bank, on the link clock
`timescale 1ns/1ps
module stdiag_link (
  input  logic                     link_clk,
  input  logic                     arst_n,
  input  logic                     req_valid,
  output logic                     req_ready,
  input  logic                     req_write,
  input  stdiag_pkg::stdiag_addr_t req_addr,
  input  stdiag_pkg::stdiag_word_t req_wdata,
  output logic                     rsp_valid,
  output stdiag_pkg::stdiag_word_t rsp_rdata,
  stdiag_xfer_if.link              xfer
);
  // ---------------------------------------------------------------
  // request toggle and held payload
  // ---------------------------------------------------------------
  logic                     busy_reg;
  logic                     tgl_reg;
  logic                     write_reg;
  stdiag_pkg::stdiag_addr_t addr_reg;
  stdiag_pkg::stdiag_word_t wdata_reg;
  logic [2:0]               ack_sync_reg;
  logic                     rsp_valid_reg;
  stdiag_pkg::stdiag_word_t rdata_reg;
  wire take     = req_valid & ~busy_reg;
  wire ack_edge = ack_sync_reg[2] ^ ack_sync_reg[1];

  // payload stays frozen until the core answers, so it crosses safely
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg  <= 1'b0;
      tgl_reg   <= 1'b0;
      write_reg <= 1'b0;
      addr_reg  <= 5'h00;
      wdata_reg <= 16'h0000;
    end else if (take) begin
      busy_reg  <= 1'b1;
      tgl_reg   <= ~tgl_reg;
      write_reg <= req_write;
      addr_reg  <= req_addr;
      wdata_reg <= req_wdata;
    end else if (ack_edge) begin
      busy_reg  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // answer side: acknowledge toggle synchronised, read word captured
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_sync_reg  <= 3'h0;
      rsp_valid_reg <= 1'b0;
      rdata_reg     <= 16'h0000;
    end else begin
      ack_sync_reg  <= {ack_sync_reg[1:0], xfer.ack_tgl};
      rsp_valid_reg <= ack_edge;
      if (ack_edge) rdata_reg <= xfer.rdata; // core holds it steady
    end
  end

  assign req_ready     = ~busy_reg;
  assign rsp_valid     = rsp_valid_reg;
  assign rsp_rdata     = rdata_reg;
  assign xfer.req_tgl  = tgl_reg;
  assign xfer.write    = write_reg;
  assign xfer.addr     = addr_reg;
  assign xfer.wdata    = wdata_reg;
endmodule : stdiag_link

// [design/stdiag_bank.sv]
// self-test diagnostic register bank with select timeout counter
// Notes on behaviour
// - fault when timeout counter reaches 10-bit limit
// - counter steps on free 1 ms timebase
// - limit resets to 0x12c, about 300 ms
// - 16-bit scratch reads back last written value
// - result zero: overvoltage test flags high byte
// - result zero: undervoltage flags, thermal at bottom
// - failure flags reset zero, set on failure
// - any failure flag drives fault output low
// - writing one clears flag, restores fault output
// - result one: analog, logic flags drive fault
// - internal logic error bit; rest reads zero
// - addresses 0x0f, 0x10, 0x11; results write-one-clear
// - trigger write starts analog test, self-clears
`timescale 1ns/1ps
`include "stdiag_regs.svh"
module stdiag_bank #(
  parameter int unsigned MS_CYCLES = `STDIAG_MS_CYCLES
) (
  input  logic                     clock,
  input  logic                     arst_n,
  input  logic                     link_clk,
  input  logic                     req_valid,
  output logic                     req_ready,
  input  logic                     req_write,
  input  stdiag_pkg::stdiag_addr_t req_addr,
  input  stdiag_pkg::stdiag_word_t req_wdata,
  output logic                     rsp_valid,
  output stdiag_pkg::stdiag_word_t rsp_rdata,
  input  logic                     select_line_n,
  input  logic [7:0]               overvolt_test_failed,
  input  logic [6:0]               undervolt_test_failed,
  input  logic                     thermal_test_failed,
  input  logic                     analog_test_failed,
  input  logic                     logic_test_failed,
  input  logic                     logic_error_seen,
  input  logic                     analog_test_done,
  output logic                     analog_test_start,
  output logic                     analog_test_trigger,
  output logic                     select_timeout_fault,
  output logic                     fault_flag_n
);
  localparam int TW = $clog2(MS_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYCLES - 1);

  // ---------------------------------------------------------------
  // link port and crossing of requests into the core domain
  // ---------------------------------------------------------------
  stdiag_xfer_if xfer ();

  stdiag_link u_link (
    .link_clk  (link_clk),
    .arst_n    (arst_n),
    .req_valid (req_valid),
    .req_ready (req_ready),
    .req_write (req_write),
    .req_addr  (req_addr),
    .req_wdata (req_wdata),
    .rsp_valid (rsp_valid),
    .rsp_rdata (rsp_rdata),
    .xfer      (xfer.link)
  );

  logic [2:0] req_sync_reg;
  logic       ack_reg;

  // request toggle: two flops to resolve, third flop for the edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) req_sync_reg <= 3'h0;
    else         req_sync_reg <= {req_sync_reg[1:0], xfer.req_tgl};
  end

  wire acc_pulse = req_sync_reg[2] ^ req_sync_reg[1];

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  stdiag_pkg::stdiag_sel_t sel;
  stdiag_pkg::stdiag_word_t wd;

  // five-bit address compare; anything else is unmapped
  assign sel =
    (xfer.addr == `STDIAG_ADDR_CFG)     ? stdiag_pkg::STDIAG_SEL_CFG :
    (xfer.addr == `STDIAG_ADDR_SCRATCH) ? stdiag_pkg::STDIAG_SEL_SCRATCH :
    (xfer.addr == `STDIAG_ADDR_MON)     ? stdiag_pkg::STDIAG_SEL_MON :
    (xfer.addr == `STDIAG_ADDR_BIST)    ? stdiag_pkg::STDIAG_SEL_BIST :
                                          stdiag_pkg::STDIAG_SEL_NONE;
  assign wd = xfer.wdata;

  wire is_wr    = acc_pulse & xfer.write;
  wire is_rd    = acc_pulse & ~xfer.write;
  wire wr_cfg   = is_wr & (sel == stdiag_pkg::STDIAG_SEL_CFG);
  wire wr_scr   = is_wr & (sel == stdiag_pkg::STDIAG_SEL_SCRATCH);
  wire wr_mon   = is_wr & (sel == stdiag_pkg::STDIAG_SEL_MON);
  wire wr_bist  = is_wr & (sel == stdiag_pkg::STDIAG_SEL_BIST);

  // ---------------------------------------------------------------
  // configuration: trigger, timeout enable and limit
  // ---------------------------------------------------------------
  logic       trig_reg;
  logic       en_reg;
  logic [9:0] limit_reg;
  logic       start_reg;

  // a trigger written while a test runs is absorbed, not restarted
  wire trig_set  = wr_cfg & wd[`STDIAG_CFG_TRIG_BIT] & ~trig_reg;
  // a completion in the same cycle wins; the write is dropped
  wire trig_next = trig_set | (trig_reg & ~analog_test_done);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trig_reg  <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      trig_reg  <= trig_next;
      start_reg <= trig_set;
    end
  end

  // limit and enable load only from the host
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      en_reg    <= `STDIAG_EN_RESET;
      limit_reg <= `STDIAG_LIMIT_RESET;
    end else if (wr_cfg) begin
      en_reg    <= wd[`STDIAG_CFG_EN_BIT];
      limit_reg <= wd[`STDIAG_LIMIT_MSB:0];
    end
  end

  // ---------------------------------------------------------------
  // loop-back scratch
  // ---------------------------------------------------------------
  stdiag_pkg::stdiag_word_t scratch_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)     scratch_reg <= `STDIAG_SCRATCH_RESET;
    else if (wr_scr) scratch_reg <= wd;
  end

  // ---------------------------------------------------------------
  // sticky self-test result registers
  // ---------------------------------------------------------------
  stdiag_pkg::stdiag_word_t mon_reg;
  stdiag_pkg::stdiag_word_t bist_reg;
  stdiag_pkg::stdiag_word_t mon_set;
  stdiag_pkg::stdiag_word_t mon_clr;
  stdiag_pkg::stdiag_word_t bist_set;
  stdiag_pkg::stdiag_word_t bist_clr;
  stdiag_pkg::stdiag_word_t mon_next;
  stdiag_pkg::stdiag_word_t bist_next;

  // overvoltage in the top byte, undervoltage below, thermal last
  assign mon_set  = {overvolt_test_failed,
                     undervolt_test_failed, thermal_test_failed};
  assign bist_set = {analog_test_failed, logic_test_failed,
                     logic_error_seen, 13'h0000};
  assign mon_clr  = wr_mon ? wd : 16'h0000;
  assign bist_clr = wr_bist ? (wd & `STDIAG_BIST_MASK) : 16'h0000;
  // a failure landing on the clearing write is kept: set wins
  assign mon_next  = (mon_reg & ~mon_clr) | mon_set;
  assign bist_next = (bist_reg & ~bist_clr) | bist_set;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mon_reg  <= `STDIAG_MON_RESET;
      bist_reg <= `STDIAG_BIST_RESET;
    end else begin
      mon_reg  <= mon_next;
      bist_reg <= bist_next;
    end
  end

  // ---------------------------------------------------------------
  // fault flag output
  // ---------------------------------------------------------------
  logic fault_n_reg;
  // the logic error bit reports only; it does not pull the flag
  wire any_fail = (|mon_reg) |
                  (|(bist_reg & `STDIAG_BIST_FAULT_MASK));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) fault_n_reg <= 1'b1;
    else         fault_n_reg <= ~any_fail;
  end

  // ---------------------------------------------------------------
  // read path and acknowledge
  // ---------------------------------------------------------------
  stdiag_pkg::stdiag_word_t cfg_word;
  stdiag_pkg::stdiag_word_t rd_word;
  stdiag_pkg::stdiag_word_t rdata_reg;

  assign cfg_word = {trig_reg, 4'h0, en_reg, limit_reg};
  // unmapped addresses read as zero and ignore writes
  assign rd_word =
    (sel == stdiag_pkg::STDIAG_SEL_CFG)     ? cfg_word :
    (sel == stdiag_pkg::STDIAG_SEL_SCRATCH) ? scratch_reg :
    (sel == stdiag_pkg::STDIAG_SEL_MON)     ? mon_reg :
    (sel == stdiag_pkg::STDIAG_SEL_BIST)    ? bist_reg :
                                              16'h0000;

  // read word is settled before the ack toggle leaves this domain
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 16'h0000;
      ack_reg   <= 1'b0;
    end else begin
      if (is_rd) rdata_reg <= rd_word;
      ack_reg <= ack_reg ^ acc_pulse;
    end
  end

  assign xfer.rdata   = rdata_reg;
  assign xfer.ack_tgl = ack_reg;

  // ---------------------------------------------------------------
  // select timeout: 1 ms timebase and counter
  // ---------------------------------------------------------------
  logic [1:0]    sel_sync_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic [9:0]    to_cnt_reg;
  logic          to_fault_reg;

  // the select pin is asynchronous to the core clock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) sel_sync_reg <= 2'b11;
    else         sel_sync_reg <= {sel_sync_reg[0], select_line_n};
  end

  wire sel_active = ~sel_sync_reg[1];
  wire ms_tick    = (tick_cnt_reg == TICK_LAST);
  wire to_run     = sel_active & en_reg;

  // free-running timebase: the first tick after select falls
  // anywhere inside the first millisecond, by design
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)      tick_cnt_reg <= '0;
    else if (ms_tick) tick_cnt_reg <= '0;
    else              tick_cnt_reg <= tick_cnt_reg + TW'(1);
  end

  // counter saturates so a long hold cannot wrap past the limit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) to_cnt_reg <= 10'h000;
    else if (!to_run) to_cnt_reg <= 10'h000;
    else if (ms_tick && to_cnt_reg != `STDIAG_LIMIT_SAT)
      to_cnt_reg <= to_cnt_reg + 10'h001;
  end

  // fault stands while select stays low past the limit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) to_fault_reg <= 1'b0;
    else to_fault_reg <= to_run & (to_cnt_reg >= limit_reg);
  end

  assign select_timeout_fault = to_fault_reg;
  assign analog_test_trigger  = trig_reg;
  assign analog_test_start    = start_reg;
  assign fault_flag_n         = fault_n_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic cfg_touched_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)     cfg_touched_reg <= 1'b0;
    else if (wr_cfg) cfg_touched_reg <= 1'b1;
  end

  chk_timeout_fault_set: assert property (
    to_run && to_cnt_reg >= limit_reg ##1 to_run |-> select_timeout_fault)
    else $error("timeout fault missing at limit");

  chk_count_on_tick: assert property (
    to_run && $past(to_run) && !$past(ms_tick) |-> $stable(to_cnt_reg))
    else $error("timeout counter moved without a tick");

  chk_limit_reset: assert property (
    !cfg_touched_reg |-> limit_reg == 10'h12c && en_reg)
    else $error("timeout limit lost its reset value");

  chk_scratch_write: assert property (
    wr_scr |=> scratch_reg == $past(wd))
    else $error("scratch did not take the written word");

  chk_scratch_loop: assert property (
    is_rd && sel == stdiag_pkg::STDIAG_SEL_SCRATCH
    |=> rdata_reg == $past(scratch_reg))
    else $error("scratch read differs from written word");

  chk_monitor_sticky: assert property (
    |mon_set |=> (mon_reg & $past(mon_set)) == $past(mon_set)
      ##1 (mon_reg & $past(mon_set, 2) & ~$past(mon_clr))
          == ($past(mon_set, 2) & ~$past(mon_clr)))
    else $error("monitor failure flag did not stick");

  chk_fault_low: assert property (
    any_fail |=> !fault_flag_n)
    else $error("fault flag high while a failure is latched");

  chk_w1c_clear: assert property (
    wr_mon && (mon_set & wd) == 16'h0000 |=> (mon_reg & $past(wd)) == 0)
    else $error("write one did not clear monitor flag");

  chk_fault_recover: assert property (
    !any_fail [*2] |-> fault_flag_n)
    else $error("fault flag stuck low after clearing");

  chk_bist_fault: assert property (
    bist_reg[`STDIAG_BIST_ANALOG_BIT] || bist_reg[`STDIAG_BIST_LOGIC_BIT]
    |=> !fault_flag_n)
    else $error("analog or logic failure not on fault flag");

  chk_bist_unused: assert property (
    is_rd && sel == stdiag_pkg::STDIAG_SEL_BIST |=> rdata_reg[12:0] == 0)
    else $error("unused result bits read nonzero");

  chk_error_quiet: assert property (
    bist_reg == 16'h2000 && mon_reg == 16'h0000 |=> fault_flag_n)
    else $error("logic error bit pulled the fault flag");

  chk_ack_follows: assert property (
    acc_pulse |=> ack_reg != $past(ack_reg))
    else $error("access not acknowledged");

  chk_trigger_clear: assert property (
    trig_reg && analog_test_done |=> !trig_reg)
    else $error("trigger not cleared on completion");

  chk_start_pulse: assert property (
    trig_set |=> analog_test_start && trig_reg ##1 !analog_test_start)
    else $error("analog test start not a single pulse");

  chk_release_zero: assert property (
    !sel_active |=> to_cnt_reg == 10'h000 && !select_timeout_fault)
    else $error("counter or fault held after select release");
endmodule : stdiag_bank

// [dv/stdiag_host.sv]
// host microcontroller model driving the request port of the diag bank
`timescale 1ns/1ps
module stdiag_host (
  output logic                     link_clk,
  output logic                     req_valid,
  input  logic                     req_ready,
  output logic                     req_write,
  output stdiag_pkg::stdiag_addr_t req_addr,
  output stdiag_pkg::stdiag_word_t req_wdata,
  input  logic                     rsp_valid,
  input  stdiag_pkg::stdiag_word_t rsp_rdata
);
  logic run;
  int   lost;

  initial begin
    link_clk  = 1'b0;
    run       = 1'b1;
    lost      = 0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = 5'h00;
    req_wdata = 16'h0000;
  end

  // link clock parks low between transfers, as a real host's does
  always #62.5 if (run || link_clk) link_clk = ~link_clk;

  // ----------------------------------------------------------------
  // one transfer: hold the request until taken, then await the answer
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input stdiag_pkg::stdiag_addr_t a,
                      input stdiag_pkg::stdiag_word_t d,
                      output stdiag_pkg::stdiag_word_t q);
    int n;
    q = 16'hxxxx;
    run = 1'b1;
    @(posedge link_clk);
    @(negedge link_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    n = 0;
    // ready only moves on rising edges, so mid-cycle sampling is safe
    while (req_ready !== 1'b1 && n < 12) begin
      @(negedge link_clk);
      n++;
    end
    if (req_ready !== 1'b1) lost++; // a port that never frees counts
    @(posedge link_clk);
    @(negedge link_clk);
    req_valid = 1'b0;
    req_addr  = ~a; // released lines do not keep their last value
    req_wdata = ~d;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 12) begin
      @(negedge link_clk);
      n++;
    end
    if (rsp_valid === 1'b1) q = rsp_rdata;
    else lost++;
    @(posedge link_clk); // one more edge lets the answer pulse end
    run = 1'b0;
  endtask : xfer
endmodule : stdiag_host

// [dv/tb.sv]
// self-checking testbench of the self-test diagnostic register bank
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin \
  bad_count++; $display("MISMATCH %0t %s", $time, msg); end end
module tb;
  localparam int unsigned MS = 20; // short millisecond keeps the run brief
  logic clock, arst_n, link_clk, req_valid, req_ready, req_write;
  logic rsp_valid, select_line_n, analog_test_done, analog_test_start;
  logic analog_test_trigger, select_timeout_fault, fault_flag_n;
  logic [15:0] mon_fail;
  logic [2:0]  bist_fail;
  stdiag_pkg::stdiag_addr_t req_addr;
  stdiag_pkg::stdiag_word_t req_wdata, rsp_rdata;
  int bad_count, comparisons, starts;

  stdiag_bank #(.MS_CYCLES(MS)) u_stdiag_bank (
    .clock(clock), .arst_n(arst_n), .link_clk(link_clk),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .select_line_n(select_line_n),
    .overvolt_test_failed(mon_fail[15:8]),
    .undervolt_test_failed(mon_fail[7:1]),
    .thermal_test_failed(mon_fail[0]), .analog_test_failed(bist_fail[2]),
    .logic_test_failed(bist_fail[1]), .logic_error_seen(bist_fail[0]),
    .analog_test_done(analog_test_done),
    .analog_test_start(analog_test_start),
    .analog_test_trigger(analog_test_trigger),
    .select_timeout_fault(select_timeout_fault), .fault_flag_n(fault_flag_n));

  stdiag_host u_stdiag_host (
    .link_clk(link_clk), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

  always #2 clock = ~clock;

  // counts test start pulses; a level here would count many times
  always @(posedge clock) if (analog_test_start === 1'b1) starts++;

  // ----------------------------------------------------------------
  // access and stimulus helpers
  // ----------------------------------------------------------------
  task automatic wr(input stdiag_pkg::stdiag_addr_t a,
                    input stdiag_pkg::stdiag_word_t d);
    stdiag_pkg::stdiag_word_t q;
    u_stdiag_host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input stdiag_pkg::stdiag_addr_t a,
                    input stdiag_pkg::stdiag_word_t e);
    stdiag_pkg::stdiag_word_t q;
    u_stdiag_host.xfer(1'b0, a, 16'h0000, q);
    `CHK(q, e, "read data")
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  // one-cycle failure report, then time for the fault flag to follow
  task automatic pulse(input logic [15:0] m, input logic [2:0] b);
    @(negedge clock);
    mon_fail  = m;
    bist_fail = b;
    @(negedge clock);
    mon_fail  = 16'h0000;
    bist_fail = 3'b000;
    cyc(4);
  endtask : pulse

  task automatic final_report;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // watchdog sized well above the expected run of about 85 us
  initial begin
    #300000;
    bad_count++;
    final_report();
  end

  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    select_line_n = 1'b1;
    mon_fail = 16'h0000;
    bist_fail = 3'b000;
    analog_test_done = 1'b0;
    bad_count = 0;
    comparisons = 0;
    starts = 0;
    repeat (12) @(negedge clock);
    repeat (2) @(posedge link_clk); // both domains must see reset
    @(negedge clock);
    arst_n = 1'b1;
    u_stdiag_host.run = 1'b0;
    cyc(2);
    `CHK(fault_flag_n, 1'b1, "fault flag after reset")
    rd(5'h10, 16'h0000);
    rd(5'h11, 16'h0000);
    rd(5'h0f, 16'h0000);
    rd(5'h0e, 16'h052c);
    // loop-back with two patterns that differ in every bit
    wr(5'h0f, 16'ha5c3);
    rd(5'h0f, 16'ha5c3);
    wr(5'h0f, 16'h5a3c);
    rd(5'h0f, 16'h5a3c);
    wr(5'h1f, 16'hffff);
    rd(5'h1f, 16'h0000);
    rd(5'h0f, 16'h5a3c);
    // every monitor flag alone: set, read, clear, fault restored
    for (int i = 0; i < 16; i++) begin
      pulse(16'h0001 << i, 3'b000);
      `CHK(fault_flag_n, 1'b0, "fault flag set")
      rd(5'h10, 16'h0001 << i);
      wr(5'h10, 16'h0001 << i);
      rd(5'h10, 16'h0000);
      cyc(4);
      `CHK(fault_flag_n, 1'b1, "fault flag cleared")
    end
    // zero writes clear nothing; one flag cleared leaves the other
    pulse(16'h8001, 3'b000);
    wr(5'h10, 16'h0000);
    rd(5'h10, 16'h8001);
    wr(5'h10, 16'h0001);
    rd(5'h10, 16'h8000);
    cyc(4);
    `CHK(fault_flag_n, 1'b0, "fault flag held")
    wr(5'h10, 16'h8000);
    // error bit, logic and analog flags; unused bits stay zero
    for (int j = 0; j < 3; j++) begin
      pulse(16'h0000, 3'b001 << j);
      `CHK(fault_flag_n, (j == 0) ? 1'b1 : 1'b0, "fault flag bist")
      rd(5'h11, 16'h2000 << j);
      wr(5'h11, 16'hffff);
      rd(5'h11, 16'h0000);
    end
    // analog test trigger sets, pulses start once, clears on done
    wr(5'h0e, 16'h852c);
    `CHK(analog_test_trigger, 1'b1, "trigger set")
    `CHK(starts, 1, "start pulses")
    rd(5'h0e, 16'h852c);
    @(negedge clock);
    analog_test_done = 1'b1;
    @(negedge clock);
    analog_test_done = 1'b0;
    cyc(3);
    `CHK(analog_test_trigger, 1'b0, "trigger cleared")
    rd(5'h0e, 16'h052c);
    // default limit: no fault at 298 ticks, fault by 300 ticks
    select_line_n = 1'b0;
    cyc(298 * MS);
    `CHK(select_timeout_fault, 1'b0, "timeout early")
    cyc(2 * MS + 10);
    `CHK(select_timeout_fault, 1'b1, "timeout due")
    select_line_n = 1'b1;
    cyc(6);
    `CHK(select_timeout_fault, 1'b0, "timeout release")
    // limit one faults within one tick of selection
    wr(5'h0e, 16'h0401);
    select_line_n = 1'b0;
    cyc(MS + 10);
    `CHK(select_timeout_fault, 1'b1, "timeout limit one")
    select_line_n = 1'b1;
    cyc(6);
    `CHK(select_timeout_fault, 1'b0, "timeout cleared")
    // counting disabled: no fault however long select is held
    wr(5'h0e, 16'h0001);
    select_line_n = 1'b0;
    cyc(3 * MS);
    `CHK(select_timeout_fault, 1'b0, "timeout disabled")
    select_line_n = 1'b1;
    `CHK(u_stdiag_host.lost, 0, "lost answers")
    final_report();
  end
endmodule : tb
